// ### pwm_pair_regs.svh
`ifndef PWM_PAIR_REGS_SVH
`define PWM_PAIR_REGS_SVH

`define PWM_CNT_WIDTH 16
`define PWM_CNT_ZERO 16'h0000
`define PWM_CNT_ONE 16'h0001
`define PWM_RELOAD_RESET 16'hFFFF
`define PWM_COMPARE_RESET 16'h0000

`endif

// ### pwm_pair_pkg.sv
package pwm_pair_pkg;

    typedef enum logic [1:0] {
        SLAVE_IDLE,
        SLAVE_COUNT
    } slave_state_type;

    typedef struct packed {
        logic [15:0] reload;
        logic [15:0] compare;
    } pwm_values_type;

    typedef struct packed {
        logic period_irq;
        logic zero_irq;
        logic running;
        logic pwm_out;
    } pwm_status_type;

endpackage

// ### paired_channel_pwm.sv
`timescale 1ns/1ps
`include "pwm_pair_regs.svh"
// How it works
// - Master reload plus one count clocks set the output period.
// - Duty equals compare over reload plus one; zero compare means always inactive.
// - Compare at or above reload plus one holds the output always active.
// - Start trigger raises period event, loads reload, then counts down.
// - Master at zero raises period event, reloads and keeps counting.
// - Master repeats until the stop trigger is written.
// - Each period event loads compare into slave counter, which counts down.
// - Slave at zero raises its event, stops, waits for next period event.
// - Output goes active one clock after period event, inactive at slave zero.
// - Reload and compare reach counters only at a period event.
module paired_channel_pwm #(
    parameter int CNT_W = `PWM_CNT_WIDTH
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic count_enable,
    input wire logic channel_start_trigger_bit,
    input wire logic channel_stop_trigger_bit,
    input wire pwm_pair_pkg::pwm_values_type values,
    output logic master_period_interrupt,
    output logic slave_zero_interrupt,
    output logic running,
    output logic pwm_output_pin,
    output logic [15:0] master_counter,
    output logic [15:0] slave_counter
);

    // ********************************************************
    // Channel pair state
    // ********************************************************
    logic run_q, run_d;
    logic [15:0] mcnt_q, mcnt_d;
    logic [15:0] scnt_q, scnt_d;
    logic mirq_q, mirq_d;
    logic sirq_q, sirq_d;
    logic out_q, out_d;
    logic full_q, full_d;
    pwm_pair_pkg::slave_state_type sst_q, sst_d;

    // Status bundle gathered so the full and zero scenario covers read as one word
    pwm_pair_pkg::pwm_status_type status;

    // ********************************************************
    // Helpers
    // ********************************************************
    // Zero test shared by both counters and by the compare decode
    function automatic logic cnt_is_zero(input logic [15:0] cnt);
        return cnt == `PWM_CNT_ZERO;
    endfunction

    // ********************************************************
    // Next state
    // ********************************************************
    // Reload and compare are sampled only on the period event, so a late write
    // waits a whole period; this is why software must write both together.
    always_comb begin
        run_d = run_q;
        mcnt_d = mcnt_q;
        scnt_d = scnt_q;
        sst_d = sst_q;
        mirq_d = 1'b0;
        sirq_d = 1'b0;
        out_d = out_q;
        full_d = full_q;
        // Stop freezes both counters where they stand; a restart reloads them anyway
        if (channel_stop_trigger_bit) begin
            run_d = 1'b0;
            out_d = 1'b0;
            sst_d = pwm_pair_pkg::SLAVE_IDLE;
        end else if (channel_start_trigger_bit) begin
            run_d = 1'b1;
            mirq_d = 1'b1;
            mcnt_d = values.reload;
        end else if (run_q && count_enable) begin
            if (cnt_is_zero(mcnt_q)) begin
                mirq_d = 1'b1;
                mcnt_d = values.reload;
            end else begin
                mcnt_d = mcnt_q - `PWM_CNT_ONE;
            end
            // Slave ends on the tick that leaves one, so the pulse spans compare ticks
            if (sst_q == pwm_pair_pkg::SLAVE_COUNT) begin
                if (scnt_q == `PWM_CNT_ONE && !full_q) begin
                    scnt_d = `PWM_CNT_ZERO;
                    sirq_d = 1'b1;
                    out_d = 1'b0;
                    sst_d = pwm_pair_pkg::SLAVE_IDLE;
                end else if (!cnt_is_zero(scnt_q)) begin
                    scnt_d = scnt_q - `PWM_CNT_ONE;
                end
            end
        end
        // Period event seen last cycle: retrigger slave, drive output active unless compare is zero
        if (mirq_q && run_q && !channel_stop_trigger_bit) begin
            scnt_d = values.compare;
            // Saturate at full scale rather than overrun the next period
            full_d = ({1'b0, values.compare} >= ({1'b0, values.reload} + 17'h00001));
            if (cnt_is_zero(values.compare)) begin
                out_d = 1'b0;
                sst_d = pwm_pair_pkg::SLAVE_IDLE;
            end else begin
                out_d = 1'b1;
                sst_d = pwm_pair_pkg::SLAVE_COUNT;
            end
        end
    end

    // ********************************************************
    // Registers
    // ********************************************************
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            run_q <= 1'b0;
            mcnt_q <= `PWM_CNT_ZERO;
            scnt_q <= `PWM_CNT_ZERO;
            sst_q <= pwm_pair_pkg::SLAVE_IDLE;
            mirq_q <= 1'b0;
            sirq_q <= 1'b0;
            out_q <= 1'b0;
            full_q <= 1'b0;
        end else begin
            run_q <= run_d;
            mcnt_q <= mcnt_d;
            scnt_q <= scnt_d;
            sst_q <= sst_d;
            mirq_q <= mirq_d;
            sirq_q <= sirq_d;
            out_q <= out_d;
            full_q <= full_d;
        end
    end

    // ********************************************************
    // Outputs
    // ********************************************************
    assign master_period_interrupt = mirq_q;
    assign slave_zero_interrupt = sirq_q;
    assign running = run_q;
    assign pwm_output_pin = out_q;
    assign master_counter = mcnt_q;
    assign slave_counter = scnt_q;
    assign status = '{period_irq: mirq_q, zero_irq: sirq_q, running: run_q, pwm_out: out_q};

    // ********************************************************
    // Checks
    // ********************************************************
    stop_quiet_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        channel_stop_trigger_bit |=> !pwm_output_pin && !running)
        else $error("output or run flag active after stop");
    start_irq_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        channel_start_trigger_bit && !channel_stop_trigger_bit |=>
            master_period_interrupt && master_counter == $past(values.reload))
        else $error("start did not raise period event with reload");
    reload_zero_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        running && count_enable && master_counter == 16'h0000 &&
        !channel_start_trigger_bit && !channel_stop_trigger_bit |=> master_period_interrupt)
        else $error("no period event at master zero");
    count_down_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        running && count_enable && master_counter != 16'h0000 &&
        !channel_start_trigger_bit && !channel_stop_trigger_bit |=>
            master_counter == $past(master_counter) - 16'h0001)
        else $error("master did not count down");
    frozen_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !running && !channel_start_trigger_bit |=> $stable(master_counter))
        else $error("master moved while stopped");
    active_after_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        master_period_interrupt && running && !channel_stop_trigger_bit &&
        values.compare != 16'h0000 |=> pwm_output_pin && slave_counter == $past(values.compare))
        else $error("output not active one clock after period event");
    zero_duty_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        master_period_interrupt && values.compare == 16'h0000 |=> !pwm_output_pin)
        else $error("zero compare drove output active");
    slave_end_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        slave_zero_interrupt |-> !pwm_output_pin && slave_counter == 16'h0000)
        else $error("slave event without inactive output");
    full_scale_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        slave_zero_interrupt |-> !full_q)
        else $error("saturated duty ended early");
    slave_count_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        running && count_enable && sst_q == pwm_pair_pkg::SLAVE_COUNT &&
        slave_counter != 16'h0000 && slave_counter != 16'h0001 && !master_period_interrupt &&
        !channel_start_trigger_bit && !channel_stop_trigger_bit |=>
            slave_counter == $past(slave_counter) - 16'h0001)
        else $error("slave did not count down");
    slave_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        sst_q == pwm_pair_pkg::SLAVE_IDLE && !master_period_interrupt |=> $stable(slave_counter))
        else $error("slave reloaded outside a period event");
    stopped_low_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !running |-> !pwm_output_pin)
        else $error("output active while stopped");
    slave_once_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        slave_zero_interrupt |=> !slave_zero_interrupt)
        else $error("slave event repeated without retrigger");

    // ********************************************************
    // Scenario covers
    // ********************************************************
    period_cov: cover property (@(posedge sys_clk) master_period_interrupt ##1 pwm_output_pin);
    full_cov: cover property (@(posedge sys_clk) full_q && status.pwm_out ##1 status.period_irq);
    zero_cov: cover property (@(posedge sys_clk)
        status.period_irq && values.compare == 16'h0000 ##1 !status.pwm_out);
    slave_cov: cover property (@(posedge sys_clk) slave_zero_interrupt);
    stop_cov: cover property (@(posedge sys_clk) running ##1 !running);

endmodule // paired_channel_pwm

// ### pwm_load_model.sv
`timescale 1ns/1ps
module pwm_load_model (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic pwm_level,
    input wire logic measure,
    output logic [15:0] high_q
);
    // Integrates drive time only; a resistive load never pushes back on the pin
    logic [15:0] high_d;
    always_comb begin
        high_d = measure ? high_q + {15'h0000, pwm_level} : 16'h0000;
    end
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            high_q <= 16'h0000;
        end else begin
            high_q <= high_d;
        end
    end
endmodule // pwm_load_model

// ### paired_channel_pwm_bench.sv
`timescale 1ns/1ps
`define CHK(what, exp, got) begin num_checks++; if ((got) !== (exp)) begin fail_count++; \
    $display("ERROR %s expected %0h seen %0h", what, exp, got); end end
module paired_channel_pwm_bench;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic count_enable = 1'b0;
    logic start = 1'b0;
    logic stop = 1'b0;
    logic measure = 1'b0;
    pwm_pair_pkg::pwm_values_type values = 32'h00000000;
    // Row: reload, compare, high cycles per period
    logic [47:0] rows [7] = '{48'h000300010001, 48'h000300000000, 48'h000300040004,
        48'h000300090004, 48'h000700050005, 48'h000000010001, 48'h000100010001};
    logic mirq, sirq, running, pwm;
    logic [15:0] mcnt, scnt, high_q, frozen;
    int fail_count = 0;
    int num_checks = 0;
    int cycles = 0;
    int mirqs;
    int w;
    paired_channel_pwm dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .count_enable(count_enable),
        .channel_start_trigger_bit(start), .channel_stop_trigger_bit(stop), .values(values),
        .master_period_interrupt(mirq), .slave_zero_interrupt(sirq), .running(running),
        .pwm_output_pin(pwm), .master_counter(mcnt), .slave_counter(scnt));
    pwm_load_model load_u (.sys_clk(sys_clk), .rst_n(rst_n), .pwm_level(pwm),
        .measure(measure), .high_q(high_q));
    always #2 sys_clk = ~sys_clk;
    task automatic complete_run();
        if (fail_count == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 2000) begin
            fail_count++;
            complete_run();
        end
    end
    task automatic trig(input logic go);
        @(posedge sys_clk);
        start <= go;
        stop <= !go;
        @(posedge sys_clk);
        start <= 1'b0;
        stop <= 1'b0;
    endtask
    task automatic wait_mirq();
        @(negedge sys_clk);
        for (int i = 0; i < 300 && mirq !== 1'b1; i++) begin
            @(negedge sys_clk);
        end
        `CHK("period event", 1'b1, mirq)
    endtask
    // ****************
    // Main sequence
    // ****************
    initial begin
        repeat (6) @(posedge sys_clk);
        rst_n <= 1'b1;
        count_enable <= 1'b1;
        @(negedge sys_clk);
        `CHK("idle pwm", 1'b0, pwm)
        foreach (rows[i]) begin
            @(posedge sys_clk);
            values <= rows[i][47:16];
            trig(1'b1);
            wait_mirq();
            w = 4 * (rows[i][47:32] + 1);
            @(posedge sys_clk);
            measure <= 1'b1;
            mirqs = 0;
            repeat (w) begin
                @(negedge sys_clk);
                mirqs += mirq;
            end
            @(posedge sys_clk);
            measure <= 1'b0;
            @(negedge sys_clk);
            `CHK("high time", 16'h0004 * rows[i][15:0], high_q)
            `CHK("periods", 4, mirqs)
            trig(1'b0);
        end
        values <= 32'h00050002;
        trig(1'b1);
        @(negedge sys_clk);
        `CHK("start event", 1'b1, mirq)
        `CHK("master load", 16'h0005, mcnt)
        `CHK("pwm late", 1'b0, pwm)
        @(negedge sys_clk);
        `CHK("pwm on", 1'b1, pwm)
        `CHK("slave load", 16'h0002, scnt)
        repeat (2) @(negedge sys_clk);
        `CHK("slave event", 1'b1, sirq)
        `CHK("pwm off", 1'b0, pwm)
        @(posedge sys_clk);
        values <= 32'h00020001;
        @(negedge sys_clk);
        `CHK("no early load", 16'h0001, mcnt)
        wait_mirq();
        `CHK("new reload", 16'h0002, mcnt)
        @(negedge sys_clk);
        `CHK("new compare", 16'h0001, scnt)
        trig(1'b0);
        repeat (2) @(negedge sys_clk);
        frozen = mcnt;
        repeat (5) @(negedge sys_clk);
        `CHK("stopped pwm", 1'b0, pwm)
        `CHK("stopped run", 1'b0, running)
        `CHK("frozen count", frozen, mcnt)
        complete_run();
    end
endmodule // paired_channel_pwm_bench
